// ---- core/ert_pkg.sv ----
// Constants, enumerations and carrier types for the embedded RAM tiles
package ert_pkg;

   // =====================================================================
   // Tile kinds and operating modes
   typedef enum logic [0:0] {
      ERT_SMALL = 1'h0,
      ERT_MEDIUM = 1'h1
   } ert_tile_e;

   typedef enum logic [2:0] {
      ERT_SDP = 3'h0,
      ERT_SP = 3'h1,
      ERT_TDP = 3'h2,
      ERT_ROM = 3'h3,
      ERT_FIFO = 3'h4,
      ERT_SHIFT = 3'h5
   } ert_mode_e;

   // =====================================================================
   // Geometry
   localparam int ERT_SMALL_BITS = 576;
   localparam int ERT_MEDIUM_BITS = 4608;
   localparam int ERT_SMALL_WIDTH = 18;
   localparam int ERT_MEDIUM_WIDTH = 36;
   localparam int ERT_LANE_BITS = 9;     // Eight data bits plus one parity bit
   localparam int ERT_MAX_W = 36;
   localparam int ERT_MAX_LANES = 4;
   localparam int ERT_PORT_AW = 8;       // Word address plus half select
   localparam int ERT_LOAD_AW = 7;

   // =====================================================================
   // Carriers
   typedef struct packed {
      ert_mode_e mode;
      logic narrow;       // Half-width words, address bit 0 picks the half
      logic bypass;       // Output register loads every mclk, ignoring its clock enable
      logic a_in_sel;     // Clock select: 0 picks tile clock 0, 1 picks clock 1
      logic a_out_sel;
      logic b_in_sel;
      logic b_out_sel;
   } ert_cfg_s;

   typedef struct packed {
      logic clken;
      logic we;
      logic rd;
      logic clr_in;
      logic clr_out;
      logic [ERT_PORT_AW-1:0] addr;
      logic [ERT_MAX_W-1:0] din;
      logic [ERT_MAX_LANES-1:0] be;
   } ert_port_s;

   typedef struct packed {
      logic valid;
      logic [ERT_LOAD_AW-1:0] addr;
      logic [ERT_MAX_W-1:0] data;
   } ert_load_s;

endpackage : ert_pkg

// ---- core/ert_ram_tile.sv ----
// Embedded RAM tile, small or medium geometry chosen by parameter
`timescale 1ns/1ps
module ert_ram_tile
   import ert_pkg::*;
#(
   parameter ert_tile_e TILE = ERT_SMALL
) (
   input logic mclk,
   input logic rst_n,
   input logic tclk0_en,
   input logic tclk1_en,
   input ert_cfg_s cfg,
   input ert_port_s port_a,
   input ert_port_s port_b,
   input ert_load_s load,
   output logic [ERT_MAX_W-1:0] dout_a,
   output logic [ERT_MAX_W-1:0] dout_b,
   output logic fifo_full,
   output logic fifo_empty
);

   // =====================================================================
   // Geometry
   localparam bit IS_SMALL = (TILE == ERT_SMALL);
   localparam int W = IS_SMALL ? ERT_SMALL_WIDTH : ERT_MEDIUM_WIDTH;
   localparam int BITS = IS_SMALL ? ERT_SMALL_BITS : ERT_MEDIUM_BITS;
   localparam int DEPTH = BITS / W;
   localparam int AW = $clog2(DEPTH);
   localparam int LANES = W / ERT_LANE_BITS;
   localparam int HL = LANES / 2;
   localparam int HW = W / 2;
   localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

   logic [W-1:0] mem [DEPTH];  // No reset: contents power up unknown unless preloaded

   // =====================================================================
   // Helpers
   function automatic logic pick(input logic sel, input logic c0, input logic c1);
      return sel ? c1 : c0;
   endfunction : pick

   function automatic logic [AW-1:0] word_of(input logic [ERT_PORT_AW-1:0] a,
                                             input logic nar);
      return nar ? a[AW:1] : a[AW-1:0];
   endfunction : word_of

   function automatic logic [LANES-1:0] lanes_of(input logic [ERT_MAX_LANES-1:0] be,
                                                 input logic nar, input logic half);
      logic [LANES-1:0] m;
      m = be[LANES-1:0];
      if (nar) begin
         m = half ? {be[HL-1:0], HL'(0)} : {HL'(0), be[HL-1:0]};
      end
      return m;
   endfunction : lanes_of

   function automatic logic [W-1:0] rd_sel(input logic [W-1:0] word, input logic nar,
                                           input logic half);
      return nar ? {HW'(0), (half ? word[W-1:HW] : word[HW-1:0])} : word;
   endfunction : rd_sel

   // =====================================================================
   // Mode decode; small tile folds a true dual-port request to simple dual-port
   ert_mode_e mode;
   logic ptr_mode;
   logic nar;
   logic load_ok;
   assign mode = (IS_SMALL && cfg.mode == ERT_TDP) ? ERT_SDP : cfg.mode;
   assign ptr_mode = (mode == ERT_FIFO) || (mode == ERT_SHIFT);
   assign nar = cfg.narrow && !ptr_mode;  // Pointer modes run full width only
   assign load_ok = !ptr_mode;

   // =====================================================================
   // Register clock enables, each group picks one of the two tile clocks
   logic ce_a_in;
   logic ce_a_out;
   logic ce_b_in;
   logic ce_b_out;
   assign ce_a_in = port_a.clken && pick(cfg.a_in_sel, tclk0_en, tclk1_en);
   assign ce_a_out = port_a.clken && pick(cfg.a_out_sel, tclk0_en, tclk1_en);
   assign ce_b_in = port_b.clken && pick(cfg.b_in_sel, tclk0_en, tclk1_en);
   assign ce_b_out = port_b.clken && pick(cfg.b_out_sel, tclk0_en, tclk1_en);

   // =====================================================================
   // FIFO and shift pointers
   logic [AW-1:0] wptr_ff;
   logic [AW-1:0] rptr_ff;
   logic [AW:0] cnt_ff;
   logic full_ff;
   logic empty_ff;
   logic fifo_push;
   logic fifo_pop;
   logic shift_step;
   logic [AW:0] nxt_cnt;
   assign fifo_push = (mode == ERT_FIFO) && ce_a_in && port_a.we && !port_a.clr_in && !full_ff;
   assign fifo_pop = (mode == ERT_FIFO) && ce_b_in && port_b.rd && !port_b.clr_in && !empty_ff;
   assign shift_step = (mode == ERT_SHIFT) && ce_a_in && port_a.we && !port_a.clr_in;
   assign nxt_cnt = cnt_ff + (AW + 1)'(fifo_push) - (AW + 1)'(fifo_pop);

   // Pointers only move on an accepted push, pop or shift
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
         cnt_ff <= '0;
         full_ff <= 1'b0;
         empty_ff <= 1'b1;
      end else begin
         if (fifo_push || shift_step) wptr_ff <= wptr_ff + AW'(1);
         if (fifo_pop) rptr_ff <= rptr_ff + AW'(1);
         cnt_ff <= nxt_cnt;
         full_ff <= (nxt_cnt == DEPTH_C);
         empty_ff <= (nxt_cnt == '0);
      end
   end

   // =====================================================================
   // Write ports; small tile never writes through port B
   logic wr_a;
   logic wr_b;
   logic [AW-1:0] wa;
   logic [AW-1:0] wb;
   logic [LANES-1:0] mask_a;
   logic [LANES-1:0] mask_b;
   logic [W-1:0] wd_a;
   logic [W-1:0] wd_b;
   assign wr_a = fifo_push || shift_step || (ce_a_in && port_a.we && !port_a.clr_in
                 && (mode == ERT_SDP || mode == ERT_SP || mode == ERT_TDP));  // ROM never writes
   assign wr_b = !IS_SMALL && mode == ERT_TDP && ce_b_in && port_b.we
                 && !port_b.clr_in;
   assign wa = ptr_mode ? wptr_ff : word_of(port_a.addr, nar);
   assign wb = word_of(port_b.addr, nar);
   assign mask_a = ptr_mode ? {LANES{1'b1}} : lanes_of(port_a.be, nar, port_a.addr[0]);
   assign mask_b = lanes_of(port_b.be, nar, port_b.addr[0]);
   assign wd_a = nar ? {2{port_a.din[HW-1:0]}} : port_a.din[W-1:0];
   assign wd_b = nar ? {2{port_b.din[HW-1:0]}} : port_b.din[W-1:0];

   // Storage; preload first so a same-cycle port write lands on top.
   // Both ports hitting one word in one cycle leaves port B's lanes.
   always_ff @(posedge mclk) begin
      if (load.valid && load_ok) mem[load.addr[AW-1:0]] <= load.data[W-1:0];
      for (int i = 0; i < LANES; i++) begin
         if (wr_a && mask_a[i]) mem[wa][i*ERT_LANE_BITS +: ERT_LANE_BITS] <=
            wd_a[i*ERT_LANE_BITS +: ERT_LANE_BITS];
         if (wr_b && mask_b[i]) mem[wb][i*ERT_LANE_BITS +: ERT_LANE_BITS] <=
            wd_b[i*ERT_LANE_BITS +: ERT_LANE_BITS];
      end
   end

   // =====================================================================
   // Read address input registers, always in the path
   logic [AW-1:0] word_a_ff;
   logic half_a_ff;
   logic [AW-1:0] word_b_ff;
   logic half_b_ff;
   logic [AW-1:0] nxt_word_b;
   assign nxt_word_b = (mode == ERT_FIFO) ? rptr_ff :
                       (mode == ERT_SHIFT) ? (shift_step ? wptr_ff + AW'(1) : wptr_ff) :
                       word_of(port_b.addr, nar);

   // Clear acts on the next mclk; the data output follows on its own clock, or every mclk with bypass set
   always_ff @(posedge mclk) begin
      if (!rst_n || port_a.clr_in) begin
         word_a_ff <= '0;
         half_a_ff <= 1'b0;
      end else if (ce_a_in) begin
         word_a_ff <= wa;
         half_a_ff <= nar && port_a.addr[0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n || port_b.clr_in) begin
         word_b_ff <= '0;
         half_b_ff <= 1'b0;
      end else if (ce_b_in && (mode != ERT_FIFO || fifo_pop)) begin
         word_b_ff <= nxt_word_b;
         half_b_ff <= nar && port_b.addr[0];
      end
   end

   // Single-port mode reads port A's address out through port B as well
   logic [W-1:0] rd_a;
   logic [W-1:0] rd_b;
   assign rd_a = rd_sel(mem[word_a_ff], nar, half_a_ff);
   assign rd_b = (mode == ERT_SP) ? rd_a : rd_sel(mem[word_b_ff], nar, half_b_ff);

   // =====================================================================
   // Output registers; bypass follows the array every mclk
   logic [ERT_MAX_W-1:0] dout_a_ff;
   logic [ERT_MAX_W-1:0] dout_b_ff;
   always_ff @(posedge mclk) begin
      if (!rst_n || port_a.clr_out) dout_a_ff <= '0;
      else if (cfg.bypass || ce_a_out) dout_a_ff <= ERT_MAX_W'(rd_a);
   end

   always_ff @(posedge mclk) begin
      if (!rst_n || port_b.clr_out) dout_b_ff <= '0;
      else if (cfg.bypass || ce_b_out) dout_b_ff <= ERT_MAX_W'(rd_b);
   end

   assign dout_a = dout_a_ff;
   assign dout_b = dout_b_ff;
   assign fifo_full = full_ff;
   assign fifo_empty = empty_ff;

   // =====================================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   AST_CAPACITY: assert property (DEPTH * W == (IS_SMALL ? 576 : 4608))
      else $error("Tile capacity differs from its geometry");
   AST_SMALL_NO_B_WRITE: assert property (IS_SMALL |-> !wr_b)
      else $error("Small tile wrote through port B");
   AST_ROM_NO_WRITE: assert property (mode == ERT_ROM |-> !wr_a && !wr_b)
      else $error("Write seen in ROM mode");
   AST_IN_CLEAR: assert property (port_b.clr_in |=> word_b_ff == '0)
      else $error("Input clear did not zero the read address");
   AST_OUT_CLEAR: assert property (port_a.clr_out |=> dout_a_ff == '0)
      else $error("Output clear did not reach the output");
   AST_WR_CLOCK: assert property (wr_a && !fifo_push |->
      (cfg.a_in_sel ? tclk1_en : tclk0_en))
      else $error("Port A write without its selected clock");
   AST_OUT_HOLD: assert property (!cfg.bypass && !ce_b_out && !port_b.clr_out
      |=> $stable(dout_b_ff))
      else $error("Registered output moved without its clock");
   AST_POWER_UP: assert property ($rose(rst_n) |-> dout_a_ff == '0 && dout_b_ff == '0)
      else $error("Outputs not cleared after reset");
   // A refused push must leave a full FIFO full; only a pop may drain it
   AST_FIFO_FULL: assert property (full_ff && !fifo_pop
      |=> full_ff && cnt_ff == DEPTH_C)
      else $error("FIFO full flag dropped without a pop");
   AST_FIFO_EMPTY: assert property (empty_ff && !fifo_push
      |=> empty_ff && cnt_ff == '0)
      else $error("FIFO empty flag dropped without a push");
   // Port B lanes win a same-word collision, so a full-mask write must land whole
   AST_B_ENABLE: assert property (wr_b && mask_b == {LANES{1'b1}}
      |=> mem[$past(wb)] == $past(wd_b))
      else $error("Port B write did not land in the array");

endmodule : ert_ram_tile

// ---- test/ert_fabric_model.sv ----
// Fabric-side model that produces the two tile clock enables
`timescale 1ns/1ps
module ert_fabric_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic slow,
   output logic tclk0_en,
   output logic tclk1_en
);
   // =====================================================================
   // Enable generation
   logic [1:0] cnt_ff;

   // Slow mode spaces the tile edges three mclk apart, with the clocks out of step
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt_ff <= 2'h0;
      end else begin
         cnt_ff <= (cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
      end
   end

   assign tclk0_en = slow ? (cnt_ff == 2'h0) : 1'b1;
   assign tclk1_en = slow ? (cnt_ff == 2'h1) : 1'b1;
endmodule : ert_fabric_model

// ---- test/tb.sv ----
// Self-checking bench for the medium RAM tile
`timescale 1ns/1ps
module tb;
   import ert_pkg::*;
   // =====================================================================
   // Signals and instances
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic slow = 1'b0;
   logic chk_vld = 1'b0;
   logic tclk0_en, tclk1_en, fifo_full, fifo_empty;
   ert_cfg_s cfg = '0;
   ert_port_s pa = '0;
   ert_port_s pb = '0;
   ert_load_s ld = '0;
   logic [ERT_MAX_W-1:0] dout_a, dout_b, d;
   logic [ERT_MAX_W-1:0] mdl [128];
   logic [ERT_MAX_W-1:0] expq [$];
   int fail_count = 0;
   int cmp_count = 0;

   always #2.5 mclk = ~mclk;

   ert_fabric_model ert_fabric_model_i (.mclk(mclk), .rst_n(rst_n), .slow(slow),
      .tclk0_en(tclk0_en), .tclk1_en(tclk1_en));

   ert_ram_tile #(.TILE(ERT_MEDIUM)) ert_ram_tile_i (.mclk(mclk), .rst_n(rst_n),
      .tclk0_en(tclk0_en), .tclk1_en(tclk1_en), .cfg(cfg), .port_a(pa), .port_b(pb),
      .load(ld), .dout_a(dout_a), .dout_b(dout_b), .fifo_full(fifo_full),
      .fifo_empty(fifo_empty));

   // =====================================================================
   // Helpers
   task chk(input logic [35:0] seen, input logic [35:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] be);
      merge = o;
      for (int i = 0; i < 4; i++) if (be[i]) merge[9*i +: 9] = n[9*i +: 9];
   endfunction : merge

   // One write cycle; eff says whether the tile should accept it
   task wr(input logic b, input logic [6:0] a, input logic [35:0] v, input logic [3:0] be,
           input logic eff);
      @(posedge mclk);
      if (b) begin
         pb.we <= 1'b1; pb.addr <= {1'b0, a}; pb.din <= v; pb.be <= be;
      end else begin
         pa.we <= 1'b1; pa.addr <= {1'b0, a}; pa.din <= v; pa.be <= be;
      end
      if (eff) mdl[a] = merge(mdl[a], v, be);
      @(posedge mclk);
      pa.we <= 1'b0; // Write enables stay low between writes
      pb.we <= 1'b0;
   endtask : wr

   // Address edge, then data edge; the watcher samples at the falling edge after it
   task rdx(input logic [6:0] a, input logic [35:0] e);
      @(posedge mclk);
      pb.addr <= {1'b0, a};
      repeat (2) @(posedge mclk);
      expq.push_back(e);
      chk_vld <= 1'b1;
      @(posedge mclk);
      chk_vld <= 1'b0;
   endtask : rdx

   // Full-width read against the model
   task rd(input logic [6:0] a);
      rdx(a, mdl[a]);
   endtask : rd

   task tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   // Watcher: oldest note against the read port
   always @(negedge mclk) if (chk_vld === 1'b1) chk(dout_b, expq.pop_front());

   initial begin
      repeat (3000) @(posedge mclk);
      fail_count++;
      tally_and_finish();
   end

   // =====================================================================
   // Main sequence
   initial begin
      void'($urandom(32'h36ae4157));
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      // Clock enables stay low so the cleared outputs are not reloaded from the array
      @(posedge mclk);
      #1;
      chk(dout_a, '0);
      chk(dout_b, '0);
      chk({35'h0, fifo_empty}, 36'h1);
      // Preload a few words in ROM mode, then a write that must be ignored
      @(posedge mclk);
      pa.clken <= 1'b1;
      pb.clken <= 1'b1;
      cfg.mode <= ERT_ROM;
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         d = {4'($urandom), $urandom};
         ld.valid <= 1'b1; ld.addr <= 7'(i); ld.data <= d;
         mdl[i] = d;
      end
      @(posedge mclk);
      ld.valid <= 1'b0;
      wr(1'b0, 7'h0, '1, 4'hf, 1'b0);
      for (int i = 0; i < 4; i++) rd(7'(i));
      // Full then lane-masked writes two mclk apart, top word included
      @(posedge mclk);
      cfg.mode <= ERT_SDP;
      for (int i = 0; i < 5; i++) begin
         wr(1'b0, 7'(i * 30 + 7), {4'($urandom), $urandom}, 4'hf, 1'b1);
         wr(1'b0, 7'(i * 30 + 7), {4'($urandom), $urandom}, 4'($urandom), 1'b1);
      end
      for (int i = 0; i < 5; i++) rd(7'(i * 30 + 7));
      // Input clear blocks a write in its cycle
      @(posedge mclk);
      pa.clr_in <= 1'b1;
      wr(1'b0, 7'd37, '0, 4'hf, 1'b0);
      pa.clr_in <= 1'b0;
      rd(7'd37);
      // Port B input clear zeroes the read address, so word 0 shows next
      @(posedge mclk);
      pb.clr_in <= 1'b1;
      repeat (2) @(posedge mclk);
      expq.push_back(mdl[0]);
      chk_vld <= 1'b1;
      pb.clr_in <= 1'b0;
      @(posedge mclk);
      chk_vld <= 1'b0;
      // Port B writes its own data in true dual-port mode
      @(posedge mclk);
      cfg.mode <= ERT_TDP;
      wr(1'b1, 7'd127, {4'($urandom), $urandom}, 4'hf, 1'b1);
      rd(7'd127);
      // Half-width write into the upper half of word 7, both halves read with the output register loading every mclk
      @(posedge mclk);
      cfg.mode <= ERT_SDP;
      cfg.narrow <= 1'b1;
      cfg.bypass <= 1'b1;
      d = {4'($urandom), $urandom};
      wr(1'b0, 7'h0f, d, 4'h3, 1'b0);
      mdl[7] = merge(mdl[7], {2{d[17:0]}}, 4'hc);
      rdx(7'h0f, {18'h0, d[17:0]});
      rdx(7'h0e, {18'h0, mdl[7][17:0]});
      // Single-port: port A's address reads out on both ports
      @(posedge mclk);
      cfg.mode <= ERT_SP;
      cfg.narrow <= 1'b0;
      cfg.bypass <= 1'b0;
      wr(1'b0, 7'd67, {4'($urandom), $urandom}, 4'hf, 1'b1);
      @(posedge mclk);
      expq.push_back(mdl[67]);
      chk_vld <= 1'b1;
      #1;
      chk(dout_a, mdl[67]);
      @(posedge mclk);
      chk_vld <= 1'b0;
      // FIFO: fill to full, one refused push, then drain in push order
      @(posedge mclk);
      cfg.mode <= ERT_FIFO;
      for (int i = 0; i < 129; i++) begin
         d = {4'($urandom), $urandom};
         if (i < 128) expq.push_back(d);
         wr(1'b0, 7'h0, d, 4'hf, 1'b0);
      end
      #1;
      chk({35'h0, fifo_full}, 36'h1);
      for (int i = 0; i < 128; i++) begin
         @(posedge mclk);
         pb.rd <= 1'b1;
         @(posedge mclk);
         pb.rd <= 1'b0;
         @(posedge mclk);
         chk_vld <= 1'b1;
         @(posedge mclk);
         chk_vld <= 1'b0;
      end
      #1;
      chk({35'h0, fifo_empty}, 36'h1);
      // Shift register: after 130 shifts the tap shows the entry 128 shifts old
      @(posedge mclk);
      cfg.mode <= ERT_SHIFT;
      for (int i = 0; i < 130; i++) wr(1'b0, 7'(i), {4'($urandom), $urandom}, 4'hf, 1'b1);
      @(posedge mclk);
      expq.push_back(mdl[2]);
      chk_vld <= 1'b1;
      @(posedge mclk);
      chk_vld <= 1'b0;
      // Output clear with sparse tile clocks lands one mclk later
      @(posedge mclk);
      slow <= 1'b1;
      pa.clr_out <= 1'b1;
      pb.clr_out <= 1'b1;
      @(posedge mclk);
      #1;
      chk(dout_a, '0);
      chk(dout_b, '0);
      @(posedge mclk);
      pa.clr_out <= 1'b0;
      pb.clr_out <= 1'b0;
      slow <= 1'b0;
      tally_and_finish();
   end
endmodule : tb
